// *** dv/buffer_sink_model.sv ***
// Byte sink standing in for the in-memory profiling buffer.
`timescale 1ns/1ps
module buffer_sink_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic slow,
    output logic      byteReady
);
    logic [7:0] stallQ;

    // ----------------------------------------------------------------
    // Acceptance
    // ----------------------------------------------------------------
    // byteReady is registered: held high while slow is low, else taken from bit 0 of an 8-bit LFSR.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stallQ    <= 8'h5a;
            byteReady <= 1'b0;
        end else begin
            stallQ    <= {stallQ[6:0], stallQ[7] ^ stallQ[5] ^ stallQ[4] ^ stallQ[3]};
            byteReady <= !slow || stallQ[0];
        end
    end
endmodule

// *** dv/profile_record_properties.sv ***
// Concurrent checks on the byte stream of the profile record encoder.
`timescale 1ns/1ps
module profile_record_properties
    import profile_record_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        sampleValid,
    input wire logic        sampleReady,
    input wire op_sample_t  sample,
    input wire logic [63:0] virtualCount,
    input wire logic [63:0] physicalCount,
    input wire logic        systemCounterOn,
    input wire byte_out_t   byteOut,
    input wire logic        byteReady
);
    logic [3:0]  idxQ;
    logic        postQ;
    logic        onQ;
    op_sample_t  sQ;
    logic [63:0] tsQ;

    function automatic logic [7:0] pay(op_sample_t s);
        if (s.kind == OP_OTHER) return {7'h00, s.isConditional};
        if (s.kind == OP_BRANCH) return {6'h00, s.isIndirect, s.isConditional};
        if (s.isVector) return {7'h02, s.isStore};
        if (s.hasOrdering | s.isExclusive | s.isAtomic)
            return {3'h0, s.hasOrdering, s.isExclusive & ~s.isAtomic, s.isAtomic, 1'b1, s.isStore};
        return {7'h00, s.isStore};
    endfunction

    // ----------------------------------------------------------------
    // Byte position within the current record
    // ----------------------------------------------------------------
    // The stamp source is latched at acceptance, as the encoder does, so later changes are ignored.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idxQ  <= 4'h0;
            postQ <= 1'b1;
            onQ   <= 1'b0;
            sQ    <= '0;
            tsQ   <= 64'h0;
        end else if (sampleValid && sampleReady) begin
            idxQ  <= 4'h0;
            postQ <= 1'b0;
            onQ   <= systemCounterOn;
            sQ    <= sample;
            tsQ   <= (sample.timeSel == TIME_VIRTUAL) ? virtualCount : physicalCount;
        end else if (byteOut.valid && byteReady) begin
            idxQ <= idxQ + 4'h1;
            if (byteOut.last) postQ <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_stall_hold: assert property (
        byteOut.valid && !byteReady |=> $stable(byteOut)) else $error("byte changed while stalled");
    chk_op_header: assert property (
        byteOut.valid && !postQ && idxQ == 4'h0 |-> byteOut.data == {6'h12, sQ.kind} && !byteOut.last)
        else $error("bad operation header");
    chk_no_cat3: assert property (
        byteOut.valid && !postQ && idxQ == 4'h0 |-> byteOut.data[1:0] != 2'h3) else $error("reserved category");
    chk_op_payload: assert property (
        byteOut.valid && !postQ && idxQ == 4'h1 |-> byteOut.data == pay(sQ) && !byteOut.last)
        else $error("bad operation payload");
    chk_stamp_header: assert property (
        byteOut.valid && idxQ == 4'h2 && sQ.timeSel != TIME_NONE && onQ |-> byteOut.data == 8'h71)
        else $error("missing stamp header");
    chk_end_byte: assert property (
        byteOut.valid && idxQ == 4'h2 && sQ.timeSel == TIME_NONE |-> byteOut.data == 8'h01 && byteOut.last)
        else $error("bad end byte");
    chk_stamp_bytes: assert property (
        byteOut.valid && !postQ && idxQ >= 4'h3
        |-> byteOut.data == tsQ[(idxQ - 4'h3) * 8 +: 8] && byteOut.last == (idxQ == 4'ha))
        else $error("bad stamp byte");
    chk_pad_zero: assert property (
        byteOut.valid && postQ |-> byteOut.data == 8'h00 && !byteOut.last) else $error("bad pad byte");
    chk_busy_refuse: assert property (
        !postQ |-> !sampleReady) else $error("sample offered mid record");
endmodule

bind profile_record_encoder profile_record_properties chk (
    .clk(clk), .arst_n(arst_n), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sample(sample), .virtualCount(virtualCount), .physicalCount(physicalCount),
    .systemCounterOn(systemCounterOn), .byteOut(byteOut), .byteReady(byteReady)
);

// *** dv/tb.sv ***
// Self-checking testbench of the profile record encoder.
`timescale 1ns/1ps
`include "profile_record_cfg.svh"
module tb;
    import profile_record_pkg::*;
    logic        clk = 0, arst_n = 0, sampleValid = 0, systemCounterOn = 0, slow = 0;
    logic        hwrite = 0, hsel = 0, sampleReady, byteReady, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdWord, lfsrState = 32'hc46023ae;
    logic [63:0] virtualCount = 64'h0, physicalCount = 64'h0;
    op_sample_t  sample = '0;
    byte_out_t   byteOut;
    logic [8:0]  expQ[$];
    int          n_fail = 0, num_checks = 0;

    always #12.5 clk = ~clk;

    profile_record_encoder DUT (.clk(clk), .arst_n(arst_n), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sample(sample), .virtualCount(virtualCount),
        .physicalCount(physicalCount), .systemCounterOn(systemCounterOn), .byteOut(byteOut),
        .byteReady(byteReady), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    buffer_sink_model sink (.clk(clk), .arst_n(arst_n), .slow(slow), .byteReady(byteReady));

    function automatic logic [31:0] nextRand();
        lfsrState = (lfsrState >> 1) ^ (lfsrState[0] ? 32'h80200003 : 32'h0);
        return lfsrState;
    endfunction

    function automatic logic [7:0] pay(op_sample_t s);
        if (s.kind == OP_OTHER) return {7'h00, s.isConditional};
        if (s.kind == OP_BRANCH) return {6'h00, s.isIndirect, s.isConditional};
        if (s.isVector) return {7'h02, s.isStore};
        if (s.hasOrdering | s.isExclusive | s.isAtomic)
            return {3'h0, s.hasOrdering, s.isExclusive & ~s.isAtomic, s.isAtomic, 1'b1, s.isStore};
        return {7'h00, s.isStore};
    endfunction

    task automatic check_byte(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) n_fail++;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) n_fail++;
        rdWord = hrdata;
        check_word({30'h0, hreadyout, hresp}, 32'h2);
    endtask

    // ----------------------------------------------------------------
    // One sample in, its whole expected record queued
    // ----------------------------------------------------------------
    task automatic record(input op_sample_t s, input logic on, input logic pad, input logic tsOff);
        logic [63:0] vc, pc, tsv;
        int          k;
        vc = {nextRand(), nextRand()};
        pc = {nextRand(), nextRand()};
        tsv = (s.timeSel == TIME_VIRTUAL) ? vc : pc;
        expQ.push_back({1'b0, 6'h12, s.kind});
        expQ.push_back({1'b0, pay(s)});
        if (s.timeSel != TIME_NONE && (on || tsOff)) begin
            expQ.push_back(9'h071);
            for (k = 0; k < 8; k++) expQ.push_back({k == 7, tsv[8 * k +: 8]});
        end else begin
            expQ.push_back(9'h101);
            if (pad) expQ.push_back(9'h000);
        end
        @(posedge clk);
        sample <= s; systemCounterOn <= on; virtualCount <= vc; physicalCount <= pc;
        sampleValid <= 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (sampleReady !== 1'b1 && k < 50);
        sampleValid <= 1'b0;
        k = 0;
        while (expQ.size() > 0 && k < 400) begin @(posedge clk); k++; end
        repeat (3) @(posedge clk);
        check_word(expQ.size(), 32'h0);
    endtask

    always @(posedge clk) begin
        if (arst_n && byteOut.valid === 1'b1 && byteReady === 1'b1) begin
            if (expQ.size() == 0) check_byte({byteOut.last, byteOut.data}, 'x);
            else check_byte({byteOut.last, byteOut.data}, expQ.pop_front());
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [31:0] r;
        op_sample_t  s;
        logic        on, pad, tsOff;
        pad = 1'b0;
        tsOff = 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        ahb(1'b0, `REG_CTRL, 32'h0);    check_word(rdWord, `CTRL_RESET);
        ahb(1'b0, `REG_RECORDS, 32'h0); check_word(rdWord, 32'h0);
        ahb(1'b1, 32'h40, 32'hffffffff);
        ahb(1'b0, 32'h40, 32'h0);       check_word(rdWord, 32'h0);
        ahb(1'b1, `REG_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        check_word({31'h0, sampleReady}, 32'h0);
        for (int i = 0; i < 48; i++) begin
            if (i % 8 == 0) begin
                r = nextRand();
                pad = r[0] | (i == 0);
                tsOff = r[1] & (i != 0);
                ahb(1'b1, `REG_CTRL, {29'h0, tsOff, pad, 1'b1});
            end
            r = nextRand();
            s = op_sample_t'(r[10:0]);
            if (r[10:9] == 2'h3) s.kind = OP_LOADSTORE;
            if (r[1:0] == 2'h3) s.timeSel = TIME_VIRTUAL;
            on = r[20];
            case (i)
                0: begin s.kind = OP_LOADSTORE; s.isVector = 0; s.isAtomic = 1; s.isExclusive = 1; end
                1: begin s.kind = OP_LOADSTORE; s.isVector = 1; s.hasOrdering = 1; end
                2: begin s.timeSel = TIME_PHYSICAL; on = 1'b0; end
                3: begin s.kind = OP_BRANCH; s.isIndirect = 1; s.isConditional = 1; end
                default: ;
            endcase
            slow <= r[31];
            record(s, on, pad, tsOff);
        end
        ahb(1'b0, `REG_STATUS, 32'h0);  check_word(rdWord, 32'h0);
        ahb(1'b0, `REG_RECORDS, 32'h0); check_word(rdWord, 32'h30);
        wrap_up();
    end
endmodule

// *** hw/profile_record_encoder.sv ***
// Encodes sampled operations into operation-type, timestamp, end and padding bytes.
`timescale 1ns/1ps
`include "profile_record_cfg.svh"

// Functional notes
// (R1) Operation-type packet: header byte then payload byte.
// (R2) Header bits 7:6=01, size 00, 3:2=10.
// (R3) Category 00 other, 01 load/store, 10 branch.
// (R4) Other payload is 0x00 or 0x01 only.
// (R5) Branch payload bits 7:2 zero, bit1 indirect.
// (R6) Branch bit 0 marks conditional branch.
// (R7) Plain general load/store: bits 7:1 zero.
// (R8) Extended access pattern 000xxx1x.
// (R9) Vector/float load/store pattern 0000010x.
// (R10) Bit 4 set for acquire or release.
// (R11) Bit 3 exclusive, zero when atomic.
// (R12) Bit 2 set for atomic.
// (R13) Bit 0 is store, clear for load.
// (R14) Single zero padding bytes may align records.
// (R15) Timestamp header 0x71 with eight payload bytes.
// (R16) Timestamp bytes sent least significant first.
// (R17) Record ends with timestamp, else end packet.
// (R18) Select virtual or physical count, none omits.
// (R19) Counter off: omit or unknown, implementation picks.
// (R20) Relaxation only when system counter is off.
// (R21) Extra packet data skipped; none produced here.
// (R22) End packet is the single byte 0x01.
// (R23) Header precedes payload at increasing positions.
module profile_record_encoder
    import profile_record_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        sampleValid,
    output logic             sampleReady,
    input  wire op_sample_t  sample,
    input  wire logic [63:0] virtualCount,
    input  wire logic [63:0] physicalCount,
    input  wire logic        systemCounterOn,
    output byte_out_t        byteOut,
    input  wire logic        byteReady,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hsel,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] records_q;
    logic        wrPend_q;
    logic [31:0] addr_q;
    logic        busy_q;
    logic [31:0] readMux;

    wire addrPhase = hsel && hready && htrans[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_q <= 1'b0;
        end else begin
            wrPend_q <= addrPhase && hwrite;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= 32'h0000_0000;
        end else if (addrPhase) begin
            addr_q <= haddr;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wrPend_q && addr_q == `REG_CTRL) begin
            ctrl_q <= {29'h0000_0000, hwdata[2:0]};
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        case (haddr)
            `REG_CTRL:    readMux = ctrl_q;
            `REG_STATUS:  readMux = {31'h0000_0000, busy_q};
            `REG_RECORDS: readMux = records_q;
            default:      readMux = 32'h0000_0000;
        endcase
    end

    // Read data is registered so the output comes from a flip-flop; the answer
    // therefore lands one cycle after the address phase, which needs no wait state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= readMux;
        end
    end

    // Every transfer, mapped or not, gets zero wait states and an OKAY answer.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Payload encoding
    // ------------------------------------------------------------------
    logic [7:0] opHeader;
    logic [7:0] opPayload;

    always_comb begin
        opHeader  = `OPTYPE_HDR_BASE; // [R2]
        opPayload = 8'h00;
        case (sample.kind)
            OP_LOADSTORE: begin
                opHeader[1:0] = `CAT_LOADSTORE; // [R3]
                opPayload[0]  = sample.isStore; // [R13]
                if (sample.isVector) begin
                    opPayload[`LS_VEC_MARK_BIT] = 1'b1; // [R9]
                end else if (sample.isAtomic || sample.hasOrdering || sample.isExclusive) begin
                    opPayload[`LS_EXT_MARK_BIT] = 1'b1; // [R8]
                    opPayload[`LS_ORDER_BIT]    = sample.hasOrdering; // [R10]
                    opPayload[`LS_INDIV_BIT]    = sample.isAtomic; // [R12]
                    opPayload[`LS_MONITOR_BIT]  = sample.isExclusive && !sample.isAtomic; // [R11]
                end
                // Plain general-register access leaves bits 7:1 clear. [R7]
            end
            OP_BRANCH: begin
                opHeader[1:0]               = `CAT_BRANCH; // [R3]
                opPayload[`BR_INDIRECT_BIT] = sample.isIndirect; // [R5]
                opPayload[0]                = sample.isConditional; // [R6]
            end
            default: begin
                opHeader[1:0] = `CAT_OTHER; // [R3]
                opPayload     = sample.isConditional ? `SUB_BRANCH_IS_GUARDED : `SUB_UNCOND; // [R4]
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Byte sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE,
        S_OPHDR,
        S_OPPAY,
        S_TSHDR,
        S_TSPAY,
        S_END,
        S_PAD
    } seq_state_t;

    seq_state_t  state_q;
    logic [7:0]  header_q;
    logic [7:0]  payload_q;
    logic [63:0] stamp_q;
    logic        withStamp_q;
    logic [3:0]  tsCount_q;
    logic        padPhase_q;
    logic        sendOk;
    logic        useStamp;
    logic        accept;
    logic        stampDone;
    logic        recordDone;

    wire outFree = !byteOut.valid || byteReady;
    assign sendOk     = outFree && state_q != S_IDLE;
    assign accept     = sampleValid && sampleReady && state_q == S_IDLE;
    assign stampDone  = sendOk && state_q == S_TSPAY && tsCount_q == `TS_BYTES - 4'h1;
    assign recordDone = stampDone || (sendOk && state_q == S_END);

    // Counter off keeps the timestamp out unless software asks for an
    // unknown-value stamp; a running but inaccessible counter is not involved.
    assign useStamp = sample.timeSel != TIME_NONE
        && (systemCounterOn || ctrl_q[`CTRL_TSOFF_EMIT_BIT]); // [R18] [R19] [R20]

    // ------------------------------------------------------------------
    // Record state
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (accept) begin
                        state_q <= S_OPHDR;
                    end
                end
                S_OPHDR: begin
                    if (sendOk) begin
                        state_q <= S_OPPAY; // [R23]
                    end
                end
                S_OPPAY: begin
                    if (sendOk) begin
                        state_q <= withStamp_q ? S_TSHDR : S_END; // [R17]
                    end
                end
                S_TSHDR: begin
                    if (sendOk) begin
                        state_q <= S_TSPAY;
                    end
                end
                S_TSPAY: begin
                    if (stampDone) begin
                        state_q <= ctrl_q[`CTRL_PAD_BIT] ? S_PAD : S_IDLE;
                    end
                end
                S_END: begin
                    if (sendOk) begin
                        state_q <= ctrl_q[`CTRL_PAD_BIT] ? S_PAD : S_IDLE;
                    end
                end
                S_PAD: begin
                    // A record is 11 bytes with a stamp or 3 without; one padding
                    // byte after a stamped record (12) is not a goal, so padding
                    // only evens a short record out to 4 bytes.
                    if (!padPhase_q || sendOk) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // The header is held here because the sampling logic may move on as
    // soon as its sample has been accepted.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            header_q  <= 8'h00;
            payload_q <= 8'h00;
        end else if (accept) begin
            header_q  <= opHeader;
            payload_q <= opPayload;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            withStamp_q <= 1'b0;
        end else if (accept) begin
            withStamp_q <= useStamp; // [R18] [R19]
        end
    end

    // ------------------------------------------------------------------
    // Stamp
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stamp_q <= 64'h0000_0000_0000_0000;
        end else if (accept) begin
            stamp_q <= (sample.timeSel == TIME_PHYSICAL)
                       ? physicalCount : virtualCount; // [R18]
        end else if (sendOk && state_q == S_TSPAY) begin
            stamp_q <= {8'h00, stamp_q[63:8]}; // [R16]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tsCount_q <= 4'h0;
        end else if (sendOk && state_q == S_TSHDR) begin
            tsCount_q <= 4'h0;
        end else if (sendOk && state_q == S_TSPAY) begin
            tsCount_q <= tsCount_q + 4'h1;
        end
    end

    // Only a record closed by the end byte asks for a padding byte.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            padPhase_q <= 1'b0;
        end else if (sendOk && state_q == S_END) begin
            padPhase_q <= 1'b1;
        end else if (stampDone) begin
            padPhase_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Handshake and status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            records_q <= 32'h0000_0000;
        end else if (recordDone) begin
            records_q <= records_q + 32'h0000_0001; // [R17]
        end
    end

    // A new sample waits until the last byte of the previous record has left,
    // so a new header never queues behind a byte the buffer holds off.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleReady <= 1'b0;
        end else begin
            sampleReady <= state_q == S_IDLE && !byteOut.valid
                && ctrl_q[`CTRL_ENABLE_BIT] && !sampleReady;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= state_q != S_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Output byte
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            byteOut <= '0;
        end else if (sendOk) begin
            case (state_q)
                S_OPHDR: begin
                    byteOut <= '{valid: 1'b1, data: header_q, last: 1'b0}; // [R1] [R23]
                end
                S_OPPAY: begin
                    byteOut <= '{valid: 1'b1, data: payload_q, last: 1'b0}; // [R1]
                end
                S_TSHDR: begin
                    byteOut <= '{valid: 1'b1, data: `TIMESTAMP_HDR, last: 1'b0}; // [R15]
                end
                S_TSPAY: begin
                    byteOut.valid <= 1'b1;
                    byteOut.data  <= stamp_q[7:0]; // [R16] [R23]
                    byteOut.last  <= tsCount_q == `TS_BYTES - 4'h1; // [R17]
                end
                S_END: begin
                    byteOut <= '{valid: 1'b1, data: `END_BYTE, last: 1'b1}; // [R22] [R17]
                end
                S_PAD: begin
                    byteOut.valid <= padPhase_q; // [R14]
                    byteOut.data  <= `PAD_BYTE;
                    byteOut.last  <= 1'b0;
                end
                default: begin
                    byteOut <= '0;
                end
            endcase
        end else if (outFree) begin
            byteOut <= '0;
        end
    end

    // Extra implementation data is never produced, so nothing must be skipped. [R21]

endmodule

// *** shared/profile_record_cfg.svh ***
// Byte codes, field positions and register offsets of the profile record encoder.
`ifndef PROFILE_RECORD_CFG_SVH
`define PROFILE_RECORD_CFG_SVH

`define OPTYPE_HDR_BASE     8'h48
`define TIMESTAMP_HDR       8'h71
`define END_BYTE            8'h01
`define PAD_BYTE            8'h00
`define CAT_OTHER           2'h0
`define CAT_LOADSTORE       2'h1
`define CAT_BRANCH          2'h2
`define SUB_UNCOND          8'h00
`define SUB_BRANCH_IS_GUARDED            8'h01
`define LS_EXT_MARK_BIT     1
`define LS_VEC_MARK_BIT     2
`define LS_ORDER_BIT        4
`define LS_MONITOR_BIT      3
`define LS_INDIV_BIT        2
`define BR_INDIRECT_BIT     1
`define TS_BYTES            4'h8

`define REG_CTRL            32'h0000_0000
`define REG_STATUS          32'h0000_0004
`define REG_RECORDS         32'h0000_0008
`define CTRL_RESET          32'h0000_0001
`define CTRL_ENABLE_BIT     0
`define CTRL_PAD_BIT        1
`define CTRL_TSOFF_EMIT_BIT 2

`endif

// *** shared/profile_record_pkg.sv ***
// Types shared by the profile record encoder.
package profile_record_pkg;

    typedef enum logic [1:0] {
        TIME_NONE,
        TIME_VIRTUAL,
        TIME_PHYSICAL
    } time_source_t;

    typedef enum logic [1:0] {
        OP_OTHER,
        OP_LOADSTORE,
        OP_BRANCH
    } op_kind_t;

    typedef struct packed {
        op_kind_t     kind;
        logic         isConditional;
        logic         isIndirect;
        logic         isVector;
        logic         isStore;
        logic         hasOrdering;
        logic         isExclusive;
        logic         isAtomic;
        time_source_t timeSel;
    } op_sample_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } byte_out_t;

endpackage
